// file: src/pfd_lock_pkg.sv
// constants shared by the phase/frequency detector block
package pfd_lock_pkg;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic FLAG_RESET = 1'b0;
   localparam logic LOCK_RESET = 1'b1;
   localparam logic PHASE_VCO_RESET = 1'b1;
   localparam logic PHASE_REF_RESET = 1'b0;
   localparam logic PUMP_LVL_RESET = 1'h0;
   localparam logic PUMP_OE_RESET = 1'h0;
   localparam logic MONITOR_RESET = 1'h0;
   // ----------------------------------------
   // synchroniser depth and pump drive codes
   // ----------------------------------------
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] PUMP_HIZ = 2'h0;
   localparam logic [1:0] PUMP_SRC = 2'h1;
   localparam logic [1:0] PUMP_SNK = 2'h2;
endpackage

// file: src/pin_sync.sv
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/10ps
module pin_sync
   import pfd_lock_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   // clock and control
   input wire logic clock,
   input wire logic srst,
   input wire logic clkEn,
   // pin and synchronised level
   input wire logic pinIn,
   output logic syncOut
);
   logic meta_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= RESET_VALUE;
         syncOut <= RESET_VALUE;
      end else if (clkEn) begin
         meta_q <= pinIn;
         syncOut <= meta_q;
      end
   end
endmodule

// file: src/phase_freq_detector_lock.sv
// phase/frequency detector with pump drive, lock indicator and divider monitor
`timescale 1ns/10ps
module phase_freq_detector_lock
   import pfd_lock_pkg::*;
(
   // clock, reset, enable
   input wire logic clock,
   input wire logic srst,
   input wire logic clkEn,
   // divided clocks from the dividers (asynchronous)
   input wire logic ref_divided_clk,
   input wire logic vco_divided_clk,
   // control pins; the pin pad resolves an open pin to high before this port
   input wire logic phase_polarity_select,
   input wire logic load_strobe,
   // main pump: drive level and enable (enable low = high impedance)
   output logic pumpOut,
   output logic pumpOe,
   // bypass pump
   output logic bypass_pump_out,
   output logic bypassOe,
   // phase outputs for an external pump
   output logic phaseRef,
   output logic phaseVco,
   // lock and monitor
   output logic lock_indicator,
   output logic monitorOut
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic refSync, vcoSync, polSync, strobeSync;

   pin_sync #(.RESET_VALUE(1'b0)) uRefSync (
      .clock(clock), .srst(srst), .clkEn(clkEn),
      .pinIn(ref_divided_clk), .syncOut(refSync));
   pin_sync #(.RESET_VALUE(1'b0)) uVcoSync (
      .clock(clock), .srst(srst), .clkEn(clkEn),
      .pinIn(vco_divided_clk), .syncOut(vcoSync));
   // open reads as high, so both selects reset high
   pin_sync #(.RESET_VALUE(1'b1)) uPolSync (
      .clock(clock), .srst(srst), .clkEn(clkEn),
      .pinIn(phase_polarity_select), .syncOut(polSync));
   pin_sync #(.RESET_VALUE(1'b1)) uStrobeSync (
      .clock(clock), .srst(srst), .clkEn(clkEn),
      .pinIn(load_strobe), .syncOut(strobeSync));

   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   logic refDly_q, vcoDly_q;
   wire refRise = refSync & ~refDly_q;
   wire vcoRise = vcoSync & ~vcoDly_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         refDly_q <= FLAG_RESET;
         vcoDly_q <= FLAG_RESET;
      end else if (clkEn) begin
         refDly_q <= refSync;
         vcoDly_q <= vcoSync;
      end
   end

   // ----------------------------------------
   // up / down flags
   // ----------------------------------------
   // up means the vco is behind and must speed up, down the reverse.
   // both rising together cancel, so the set and clear collapse to a clear of both flags
   logic up_q, down_q, up_d, down_d;
   wire bothSet = (refRise | up_q) & (vcoRise | down_q);
   assign up_d = bothSet ? 1'b0 : (refRise | up_q);
   assign down_d = bothSet ? 1'b0 : (vcoRise | down_q);

   always_ff @(posedge clock) begin
      if (srst) begin
         up_q <= FLAG_RESET;
         down_q <= FLAG_RESET;
      end else if (clkEn) begin
         up_q <= up_d;
         down_q <= down_d;
      end
   end

   // ----------------------------------------
   // output decode
   // ----------------------------------------
   // with select high: up drives the pump high and pulls both phases low,
   // down drives it low and raises both phases; select low swaps them
   wire raiseDrive = polSync ? up_d : down_d;
   wire lowerDrive = polSync ? down_d : up_d;
   wire [1:0] pumpCode = raiseDrive ? PUMP_SRC :
      (lowerDrive ? PUMP_SNK : PUMP_HIZ);
   wire pumpOn = (pumpCode != PUMP_HIZ);
   wire pumpLvl = (pumpCode == PUMP_SRC);
   // idle: vco phase high, reference phase low
   wire phaseVcoD = ~raiseDrive;
   wire phaseRefD = lowerDrive;
   wire lockD = ~(up_d | down_d);
   wire monitorD = polSync ? refSync : vcoSync;

   always_ff @(posedge clock) begin
      if (srst) begin
         pumpOut <= PUMP_LVL_RESET;
         pumpOe <= PUMP_OE_RESET;
         bypass_pump_out <= PUMP_LVL_RESET;
         bypassOe <= PUMP_OE_RESET;
      end else if (clkEn) begin
         pumpOut <= pumpLvl;
         pumpOe <= pumpOn;
         bypass_pump_out <= pumpLvl;
         bypassOe <= pumpOn & strobeSync;
      end
   end

   // the phase pair is registered from the same next-value flags as the pump,
   // so an external pump sees both edges on the same clock
   always_ff @(posedge clock) begin
      if (srst) begin
         phaseRef <= PHASE_REF_RESET;
         phaseVco <= PHASE_VCO_RESET;
      end else if (clkEn) begin
         phaseRef <= phaseRefD;
         phaseVco <= phaseVcoD;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         lock_indicator <= LOCK_RESET;
         monitorOut <= MONITOR_RESET;
      end else if (clkEn) begin
         lock_indicator <= lockD;
         monitorOut <= monitorD;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst || !clkEn);

   sequence upHeld;
      up_q && !down_q;
   endsequence

   AST_LOCK_NOR: assert property (lock_indicator == !(up_q || down_q))
      else $error("lock indicator is not the nor of up and down");
   AST_FLAGS_EXCL: assert property (!(up_q && down_q))
      else $error("up and down both set");
   AST_IDLE_PHASE: assert property (!up_q && !down_q |-> phaseVco && !phaseRef)
      else $error("idle phase outputs wrong");
   AST_HIZ_IDLE: assert property (!up_q && !down_q |-> !pumpOe && !bypassOe)
      else $error("pump driven while idle");
   AST_MON_SEL: assert property (##1 $past(polSync) |-> monitorOut == $past(refSync))
      else $error("monitor does not follow reference clock");
   AST_MON_VCO: assert property (##1 !$past(polSync) |-> monitorOut == $past(vcoSync))
      else $error("monitor does not follow vco clock");
   AST_UP_DRIVE: assert property (upHeld and $past(polSync) |-> pumpOe && pumpOut
      && !phaseVco && !phaseRef)
      else $error("up with high select drives wrong levels");
   AST_UP_DRIVE_INV: assert property (upHeld and !$past(polSync) |-> pumpOe && !pumpOut
      && phaseVco && phaseRef)
      else $error("up with low select drives wrong levels");
   AST_BYPASS_OFF: assert property (##1 !$past(strobeSync) |-> !bypassOe)
      else $error("bypass pump driven with load strobe low");
   AST_BYPASS_COPY: assert property (strobeSync ##1 strobeSync |->
      bypassOe == pumpOe)
      else $error("bypass pump does not copy main pump");
   AST_UP_SET: assert property (refRise && !vcoRise && !down_q |=> up_q)
      else $error("reference edge did not set up");

   // ----------------------------------------
   // step sequences for the flag machine
   // ----------------------------------------
   sequence downHeld;
      down_q && !up_q;
   endsequence

   sequence idleFlags;
      !up_q && !down_q;
   endsequence

   sequence refAlone;
      refRise && !vcoRise;
   endsequence

   sequence vcoAlone;
      vcoRise && !refRise;
   endsequence

   sequence bothRise;
      refRise && vcoRise;
   endsequence

   // ----------------------------------------
   // flag machine
   // ----------------------------------------
   AST_DOWN_SET: assert property (vcoAlone ##0 !up_q |=> downHeld)
      else $error("vco edge did not set down");

   // a second edge of the same clock only keeps the flag: the +/-2pi range
   AST_UP_KEEP: assert property (up_q && !vcoRise |=> upHeld)
      else $error("up dropped without a vco edge");

   AST_DOWN_KEEP: assert property (down_q && !refRise |=> downHeld)
      else $error("down dropped without a reference edge");

   AST_UP_CLEAR: assert property (vcoAlone ##0 up_q |=> idleFlags)
      else $error("vco edge did not clear up");

   AST_DOWN_CLEAR: assert property (refAlone ##0 down_q |=> idleFlags)
      else $error("reference edge did not clear down");

   // ideal detector: coincident edges cancel rather than leave a spike
   AST_BOTH_CANCEL: assert property (bothRise ##0 idleFlags |=> idleFlags)
      else $error("coincident edges left a flag set");

   AST_REF_ONE_CYCLE: assert property (refRise |=> !refRise)
      else $error("reference edge seen twice");

   AST_VCO_ONE_CYCLE: assert property (vcoRise |=> !vcoRise)
      else $error("vco edge seen twice");

   // ----------------------------------------
   // pump and phase outputs
   // ----------------------------------------
   AST_DOWN_DRIVE: assert property (downHeld and $past(polSync) |-> pumpOe && !pumpOut
      && phaseVco && phaseRef)
      else $error("down with high select drives wrong levels");

   AST_DOWN_DRIVE_INV: assert property (downHeld and !$past(polSync) |-> pumpOe && pumpOut
      && !phaseVco && !phaseRef)
      else $error("down with low select drives wrong levels");

   // level reads low whenever the enable says high impedance
   AST_HIZ_LEVEL: assert property (!pumpOe |-> !pumpOut)
      else $error("pump level high while released");

   AST_MAIN_ACTIVE: assert property (up_q || down_q |-> pumpOe)
      else $error("main pump idle while a flag is set");

   AST_PUMP_LOCK: assert property (pumpOe == !lock_indicator)
      else $error("pump enable and lock indicator disagree");

   AST_PHASE_ORDER: assert property (phaseRef |-> phaseVco)
      else $error("reference phase high with vco phase low");

   // ----------------------------------------
   // bypass pump
   // ----------------------------------------
   AST_BYPASS_FOLLOW: assert property (strobeSync |=> bypassOe == pumpOe)
      else $error("bypass enable does not follow main enable");

   AST_BYPASS_LEVEL: assert property (bypassOe |-> bypass_pump_out == pumpOut)
      else $error("bypass level differs from main level");

   // ----------------------------------------
   // lock indicator
   // ----------------------------------------
   AST_LOCK_FALL: assert property ($fell(lock_indicator) |-> up_q || down_q)
      else $error("lock indicator fell with no flag set");

   AST_LOCK_RISE: assert property ($rose(lock_indicator) |-> !up_q && !down_q)
      else $error("lock indicator rose with a flag set");

   AST_LOCK_PULSE: assert property (refAlone ##0 (!up_q && !down_q) |=> !lock_indicator)
      else $error("lock indicator missed a reference edge");

   // ----------------------------------------
   // reset and clock enable: own disable, since the defaults mask both
   // ----------------------------------------
   AST_RESET_IDLE: assert property (@(posedge clock) disable iff (1'b0) srst |=>
      !pumpOe && !bypassOe && phaseVco && !phaseRef && lock_indicator)
      else $error("outputs not idle after reset");

   AST_FREEZE_FLAGS: assert property (@(posedge clock) disable iff (srst) !clkEn |=>
      $stable(up_q) && $stable(down_q))
      else $error("flags moved while frozen");

   AST_FREEZE_OUTS: assert property (@(posedge clock) disable iff (srst) !clkEn |=>
      $stable(pumpOe) && $stable(pumpOut) && $stable(lock_indicator))
      else $error("pump or lock moved while frozen");

   AST_FREEZE_PHASE: assert property (@(posedge clock) disable iff (srst) !clkEn |=>
      $stable(phaseRef) && $stable(phaseVco) && $stable(monitorOut))
      else $error("phase or monitor moved while frozen");
endmodule

// file: tb/divider_model.sv
// far-side model: divided reference and vco clocks
`timescale 1ns/10ps
module divider_model (
   // clock
   input wire logic clock,
   // divided clocks
   output logic refClk,
   output logic vcoClk
);
   initial begin
      refClk = 1'b0;
      vcoClk = 1'b0;
   end
   // ----------------------------------------
   // one divider edge
   // ----------------------------------------
   // 4 clocks high and 4 low, above the 2-clock minimum for a clean edge
   task automatic fire(input logic isRef);
      @(posedge clock);
      #1;
      if (isRef) refClk = 1'b1;
      else vcoClk = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      refClk = 1'b0;
      vcoClk = 1'b0;
      repeat (4) @(posedge clock);
   endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the phase/frequency detector
`timescale 1ns/10ps
module testbench;
   import pfd_lock_pkg::*;
   logic clock, srst, clkEn, sel, strobe, refClk, vcoClk;
   logic pumpOut, pumpOe, bypassOut, bypassOe, phaseRef, phaseVco, lockOut, monitorOut;
   wire logic [6:0] outs;
   int fails = 0;
   int samples_checked = 0;
   assign outs = {pumpOe, pumpOut, bypassOe, bypassOut, phaseRef, phaseVco, lockOut};
   phase_freq_detector_lock i_dut (.clock(clock), .srst(srst), .clkEn(clkEn),
      .ref_divided_clk(refClk), .vco_divided_clk(vcoClk), .phase_polarity_select(sel),
      .load_strobe(strobe), .pumpOut(pumpOut), .pumpOe(pumpOe),
      .bypass_pump_out(bypassOut), .bypassOe(bypassOe), .phaseRef(phaseRef),
      .phaseVco(phaseVco), .lock_indicator(lockOut), .monitorOut(monitorOut));
   divider_model i_far (.clock(clock), .refClk(refClk), .vcoClk(vcoClk));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [6:0] got, input logic [6:0] exp);
      #2;
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // select and strobe take 2 clocks through their synchronisers
   task automatic setup(input logic s, input logic b);
      @(posedge clock);
      #1;
      sel = s;
      strobe = b;
      repeat (5) @(posedge clock);
   endtask
   // first edge must hold its flag; the second edge restores the lock state
   task automatic pair(input logic firstRef, input logic [6:0] exp);
      fork
         i_far.fire(firstRef);
         begin
            repeat (6) @(posedge clock);
            check({6'h00, monitorOut}, {6'h00, firstRef ~^ sel});
         end
      join
      check(outs, exp);
      i_far.fire(!firstRef);
      check(outs, 7'h03);
   endtask
   task automatic test_reset;
      check(outs, 7'h03);
      $display("done reset state");
   endtask
   task automatic test_slow_vco;
      setup(1'b1, 1'b1);
      pair(1'b1, 7'h78);
      i_far.fire(1'b1);
      i_far.fire(1'b1);
      check(outs, 7'h78);
      i_far.fire(1'b0);
      check(outs, 7'h03);
      $display("done slow vco");
   endtask
   task automatic test_fast_vco;
      setup(1'b1, 1'b0);
      pair(1'b0, 7'h46);
      $display("done fast vco");
   endtask
   task automatic test_inverted;
      setup(1'b0, 1'b0);
      pair(1'b0, 7'h68);
      setup(1'b0, 1'b1);
      pair(1'b1, 7'h56);
      $display("done inverted polarity");
   endtask
   // a vco pulse wholly inside a freeze is missed; a mid-run reset clears a held flag
   task automatic test_freeze;
      setup(1'b1, 1'b1);
      i_far.fire(1'b1);
      check(outs, 7'h78);
      @(posedge clock);
      #1;
      clkEn = 1'b0;
      i_far.fire(1'b0);
      check(outs, 7'h78);
      @(posedge clock);
      #1;
      clkEn = 1'b1;
      i_far.fire(1'b0);
      check(outs, 7'h03);
      i_far.fire(1'b1);
      @(posedge clock);
      #1;
      srst = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      srst = 1'b0;
      repeat (3) @(posedge clock);
      check(outs, 7'h03);
      $display("done freeze and reset");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clock);
      fails++;
      complete_run();
   end
   initial begin
      srst = 1'b1;
      clkEn = 1'b1;
      sel = 1'b1;
      strobe = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      srst = 1'b0;
      repeat (3) @(posedge clock);
      test_reset();
      test_slow_vco();
      test_fast_vco();
      test_inverted();
      test_freeze();
      complete_run();
   end
endmodule
